// *** core/rsmr_regs.svh ***
// Timing constants for the reset, strap and management-ready sequencer.
// Assumes a 250 MHz core clock on mclk.
`ifndef RSMR_REGS_SVH
`define RSMR_REGS_SVH
`define RSMR_CLK_PERIOD_PS     4000
`define RSMR_RESET_PULSE_MIN_NS 5000
`define RSMR_STRAP_HOLD_US     1000
`define RSMR_MGMT_READY_US     40000
`define RSMR_ATTACH_READY_NS   11500000
`define RSMR_ATTACH_CMD        16'hAA56
// Whole-ns arithmetic: picosecond products would overflow 32-bit integers
`define RSMR_CLK_PERIOD_NS     (`RSMR_CLK_PERIOD_PS / 1000)
`define RSMR_STRAP_CYC   (((`RSMR_STRAP_HOLD_US * 1000) + `RSMR_CLK_PERIOD_NS - 1) / `RSMR_CLK_PERIOD_NS)
`define RSMR_MGMT_CYC    (((`RSMR_MGMT_READY_US * 1000) + `RSMR_CLK_PERIOD_NS - 1) / `RSMR_CLK_PERIOD_NS)
`define RSMR_ATTACH_CYC  ((`RSMR_ATTACH_READY_NS + `RSMR_CLK_PERIOD_NS - 1) / `RSMR_CLK_PERIOD_NS)
`define RSMR_PULSE_CYC   ((`RSMR_RESET_PULSE_MIN_NS + `RSMR_CLK_PERIOD_NS - 1) / `RSMR_CLK_PERIOD_NS)
`endif

// *** core/rsmr_pkg.sv ***
// Types for the reset, strap and management-ready sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rsmr_pkg;
    typedef enum logic [1:0] {
        RSMR_IN_RESET,
        RSMR_WAIT_READY,
        RSMR_READY,
        RSMR_WAIT_ATTACH
    } rsmr_state_t;
endpackage
`default_nettype wire

// *** core/rsmr_sync.sv ***
// Two-flop synchroniser for the external reset pin.
// Assumes the pin is asynchronous to mclk.
`default_nettype none
module rsmr_sync (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Level in and out
    input  wire logic din,
    output var  logic dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule
`default_nettype wire

// *** core/rsmr_top.sv ***
// Reset, strap latching and management-port ready timing for a hub core.
// Assumes a stable 250 MHz mclk and sys_rst as power-on reset.
//
// Overview of operation
// - Straps are latched a hold window after power-on and after each external reset pin release.
// - Reset strap timing holds only after power-on reset has finished.
// - Management slave ready no sooner than 40 ms after power-on or reset.
// - After attach command ack, management bus idle at least 11.5 ms.
// - Runtime management access forces internal clocks on during suspend.
`include "rsmr_regs.svh"
`default_nettype none
module rsmr_top #(
    parameter int STRAP_W     = 8,
    parameter int STRAP_CYC   = `RSMR_STRAP_CYC,
    parameter int MGMT_CYC    = `RSMR_MGMT_CYC,
    parameter int ATTACH_CYC  = `RSMR_ATTACH_CYC
) (
    // Clock and power-on reset
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    // Board pins
    input  wire logic               ext_reset_n,
    input  wire logic               upstream_power_sense,
    input  wire logic [STRAP_W-1:0] strap_pins,
    // Management slave side
    input  wire logic               attach_ack,
    input  wire logic [15:0]        attach_code,
    input  wire logic               host_suspend,
    // Outputs
    output var  logic               core_rst,
    output var  logic [STRAP_W-1:0] strap_value,
    output var  logic               strap_valid,
    output var  logic               mgmt_ready,
    output var  logic               clk_force_on,
    output var  logic               power_present
);
    import rsmr_pkg::*;

    // ****************************************
    // Reset pin synchroniser
    // ****************************************
    logic rst_pin_sync;

    rsmr_sync u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .din     (ext_reset_n),
        .dout    (rst_pin_sync)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    rsmr_state_t      state;
    rsmr_state_t      next_state;
    logic [31:0]      timer;
    logic [31:0]      next_timer;
    logic [31:0]      strap_timer;
    logic [31:0]      next_strap_timer;
    logic [STRAP_W-1:0] next_strap_value;
    logic             next_strap_valid;
    logic             runtime_access;
    logic             next_runtime_access;
    logic             pin_low;
    logic             attach_hit;

    assign pin_low    = !rst_pin_sync;
    assign attach_hit = attach_ack && (attach_code == `RSMR_ATTACH_CMD);

    always_comb begin
        next_state          = state;
        next_timer          = timer;
        next_strap_timer    = strap_timer;
        next_strap_value    = strap_value;
        next_strap_valid    = strap_valid;
        next_runtime_access = runtime_access;
        // Straps tracked while held low, frozen after hold window
        if (pin_low) begin
            next_strap_value = strap_pins;
            next_strap_valid = 1'b0;
            next_strap_timer = 32'h0;
        end else if (!strap_valid) begin
            // Sampling through the hold window covers both power-on and pin release
            next_strap_value = strap_pins;
            if (strap_timer >= 32'(STRAP_CYC - 1)) begin
                next_strap_valid = 1'b1;
            end else begin
                next_strap_timer = strap_timer + 32'h1;
            end
        end
        case (state)
            RSMR_IN_RESET: begin
                next_timer = 32'h0;
                if (!pin_low) begin
                    next_state = RSMR_WAIT_READY;
                end
            end
            RSMR_WAIT_READY: begin
                if (timer >= 32'(MGMT_CYC - 1)) begin
                    next_state = RSMR_READY;
                end else begin
                    next_timer = timer + 32'h1;
                end
            end
            RSMR_READY: begin
                next_timer = 32'h0;
                if (attach_hit) begin
                    next_state          = RSMR_WAIT_ATTACH;
                    next_runtime_access = 1'b1;
                end
            end
            RSMR_WAIT_ATTACH: begin
                if (timer >= 32'(ATTACH_CYC - 1)) begin
                    next_state = RSMR_READY;
                end else begin
                    next_timer = timer + 32'h1;
                end
            end
            default: next_state = RSMR_IN_RESET;
        endcase
        if (pin_low) begin
            next_state          = RSMR_IN_RESET;
            next_runtime_access = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state          <= RSMR_IN_RESET;
            timer          <= 32'h0;
            strap_timer    <= 32'h0;
            strap_value    <= '0;
            strap_valid    <= 1'b0;
            runtime_access <= 1'b0;
        end else begin
            state          <= next_state;
            timer          <= next_timer;
            strap_timer    <= next_strap_timer;
            strap_value    <= next_strap_value;
            strap_valid    <= next_strap_valid;
            runtime_access <= next_runtime_access;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic next_core_rst;
    logic next_mgmt_ready;
    logic next_clk_force_on;
    logic next_power_present;

    always_comb begin
        next_core_rst      = (next_state == RSMR_IN_RESET);
        next_mgmt_ready    = (next_state == RSMR_READY);
        // Without this the slave goes deaf once the host suspends the hub
        next_clk_force_on  = next_runtime_access && host_suspend;
        next_power_present = upstream_power_sense;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            core_rst      <= 1'b1;
            mgmt_ready    <= 1'b0;
            clk_force_on  <= 1'b0;
            power_present <= 1'b0;
        end else begin
            core_rst      <= next_core_rst;
            mgmt_ready    <= next_mgmt_ready;
            clk_force_on  <= next_clk_force_on;
            power_present <= next_power_present;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    logic [31:0] rdy_gap;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdy_gap <= 32'h0;
        end else if (core_rst || !mgmt_ready && state == RSMR_WAIT_ATTACH) begin
            rdy_gap <= 32'h0;
        end else if (!mgmt_ready) begin
            rdy_gap <= rdy_gap + 32'h1;
        end
    end

    property p_reset_hold;
        @(posedge mclk) disable iff (sys_rst) pin_low |=> core_rst;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("core not in reset");

    property p_ready_late;
        @(posedge mclk) disable iff (sys_rst)
            $rose(mgmt_ready) && $past(state) == RSMR_WAIT_READY |-> rdy_gap >= 32'(MGMT_CYC - 1);
    endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready too early");

    property p_attach_drop;
        @(posedge mclk) disable iff (sys_rst)
            state == RSMR_READY && attach_hit && !pin_low |=> !mgmt_ready;
    endproperty
    a_attach_drop: assert property (p_attach_drop) else $error("ready after attach");

    property p_strap_latch;
        @(posedge mclk) disable iff (sys_rst) pin_low |=> strap_value == $past(strap_pins) && !strap_valid;
    endproperty
    a_strap_latch: assert property (p_strap_latch) else $error("strap not latched");

    property p_strap_frozen;
        @(posedge mclk) disable iff (sys_rst) strap_valid && !pin_low |=> $stable(strap_value);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) else $error("strap moved");

    property p_clk_force;
        @(posedge mclk) disable iff (sys_rst)
            runtime_access && host_suspend && !pin_low |=> clk_force_on;
    endproperty
    a_clk_force: assert property (p_clk_force) else $error("clocks not forced");

    c_ready:   cover property (@(posedge mclk) disable iff (sys_rst) $rose(mgmt_ready));
    c_attach:  cover property (@(posedge mclk) disable iff (sys_rst) state == RSMR_WAIT_ATTACH);
    c_pin_rst: cover property (@(posedge mclk) disable iff (sys_rst) $fell(rst_pin_sync));
endmodule
`default_nettype wire

// *** dv/rsmr_partner.sv ***
// Far-side model: reset circuit, strap resistors and management master.
// Assumes the bench calls its tasks and mclk runs without pause.
`default_nettype none
module rsmr_partner (
    // Clock
    input  wire logic        mclk,
    // Board pins and master side
    output var  logic        ext_reset_n,
    output var  logic        upstream_power_sense,
    output var  logic [7:0]  strap_pins,
    output var  logic        attach_ack,
    output var  logic [15:0] attach_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin high at start: reset pin unused at power-on, straps steady
    initial begin
        ext_reset_n = 1'b1;
        upstream_power_sense = 1'b0;
        strap_pins = 8'h5A;
        attach_ack = 1'b0;
        attach_code = 16'h0000;
    end
    // Low time at least 1250 cycles; clock already stable; straps kept after
    task automatic pulse_reset(input logic [7:0] s, input int low_cyc);
        @(negedge mclk);
        strap_pins = s;
        ext_reset_n = 1'b0;
        repeat (low_cyc) @(negedge mclk);
        ext_reset_n = 1'b1;
    endtask
    task automatic set_straps(input logic [7:0] s);
        @(negedge mclk);
        strap_pins = s;
    endtask
    task automatic set_power(input logic v);
        @(negedge mclk);
        upstream_power_sense = v;
    endtask
    // Caller issues only once ready, then idles for the attach delay
    task automatic send_cmd(input logic [15:0] c);
        @(negedge mclk);
        attach_ack = 1'b1;
        attach_code = c;
        @(negedge mclk);
        attach_ack = 1'b0;
        attach_code = ~c;
    endtask
endmodule
`default_nettype wire

// *** dv/rsmr_tb_top.sv ***
// Self-checking bench for the reset and management-ready sequencer.
// Assumes short counts: strap 8, ready 20, attach 10 cycles.
`default_nettype none
module rsmr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MGMT = 20;
    localparam int ATT = 10;
    logic mclk = 1'b0, sys_rst, host_suspend;
    logic ext_reset_n, power_sense, ack, core_rst, strap_valid;
    logic mgmt_ready, clk_force_on, power_present;
    logic [7:0] pins, strap_value;
    logic [15:0] code;
    int error_cnt = 0, samples_checked = 0;
    always #2 mclk = ~mclk;
    rsmr_partner far (.mclk(mclk), .ext_reset_n(ext_reset_n),
        .upstream_power_sense(power_sense), .strap_pins(pins),
        .attach_ack(ack), .attach_code(code));
    rsmr_top #(.STRAP_CYC(8), .MGMT_CYC(MGMT), .ATTACH_CYC(ATT)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .ext_reset_n(ext_reset_n),
        .upstream_power_sense(power_sense), .strap_pins(pins), .attach_ack(ack),
        .attach_code(code), .host_suspend(host_suspend), .core_rst(core_rst),
        .strap_value(strap_value), .strap_valid(strap_valid), .mgmt_ready(mgmt_ready),
        .clk_force_on(clk_force_on), .power_present(power_present));
    task automatic stop_test();
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait for ready; n counts falling edges spent
    task automatic wait_ready(output int n);
        n = 0;
        while (mgmt_ready !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n > 500) begin
                check("ready_timeout", 16'h0, 16'h1);
                stop_test();
            end
        end
    endtask
    task automatic power_on();
        int n;
        check("core_rst", {15'h0, core_rst}, 16'h1);
        wait_ready(n);
        check("ready_not_early", {15'h0, n >= MGMT}, 16'h1);
        check("strap_value", {8'h0, strap_value}, 16'h005A);
        check("strap_valid", {15'h0, strap_valid}, 16'h1);
        far.set_straps(8'hC3);
        repeat (4) @(negedge mclk);
        check("strap_frozen", {8'h0, strap_value}, 16'h005A);
    endtask
    task automatic pin_reset();
        int n;
        fork
            far.pulse_reset(8'h3C, 1250);
            begin
                repeat (6) @(negedge mclk);
                check("core_rst_pin", {15'h0, core_rst}, 16'h1);
                check("ready_in_reset", {15'h0, mgmt_ready}, 16'h0);
                check("strap_valid_in_reset", {15'h0, strap_valid}, 16'h0);
            end
        join
        wait_ready(n);
        check("ready_after_pin", {15'h0, n >= MGMT}, 16'h1);
        check("strap_relatch", {8'h0, strap_value}, 16'h003C);
    endtask
    task automatic attach();
        int n;
        host_suspend = 1'b1;
        far.send_cmd(16'h1234);
        repeat (3) @(negedge mclk);
        check("ready_other_code", {15'h0, mgmt_ready}, 16'h1);
        check("clk_force_idle", {15'h0, clk_force_on}, 16'h0);
        far.send_cmd(16'hAA56);
        check("ready_drop", {15'h0, mgmt_ready}, 16'h0);
        check("clk_force_on", {15'h0, clk_force_on}, 16'h1);
        wait_ready(n);
        check("attach_delay", {15'h0, n + 1 >= ATT}, 16'h1);
        host_suspend = 1'b0;
        repeat (2) @(negedge mclk);
        check("clk_force_awake", {15'h0, clk_force_on}, 16'h0);
    endtask
    task automatic power_sense_follow();
        far.set_power(1'b1);
        repeat (2) @(negedge mclk);
        check("power_on", {15'h0, power_present}, 16'h1);
        far.set_power(1'b0);
        repeat (2) @(negedge mclk);
        check("power_off", {15'h0, power_present}, 16'h0);
    endtask
    initial begin
        sys_rst = 1'b1;
        host_suspend = 1'b0;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        power_on();
        pin_reset();
        attach();
        power_sense_follow();
        stop_test();
    end
endmodule
`default_nettype wire
